// ==== rtl/wdg_top.sv ====
// Watchdog downcounter with reset generation and AHB-Lite registers
// Summary of operation
// RL1 - Hardware option keeps watchdog always active
// RL2 - Software option: set once, reset only clears
// RL3 - Counter decrements every 3072 clock cycles
// RL4 - Timeout programmable in 64 period steps
// RL5 - Guard zero while active pulses reset low
// RL6 - Software reloads counter before guard reaches zero
// RL7 - Software reloads only FEh down to 02h
// RL8 - Timeouts scale as periods times count
// RL9 - Software sets activation, guard, then count
// RL10 - Writing guard zero while active resets
// RL11 - Inactive software option gives 7-bit timer
// RL12 - Software option code tests activation bit
// RL13 - Choose hardware option, stop pin high
// RL14 - Stop pin held low while protection needed
// RL15 - Register: count bits reversed, guard, activation
// RL16 - Count register resets to FEh
// RL17 - Stop with pin high freezes counter
// RL18 - Write reloads counter, period restarts
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module wdg_top
    import wdg_pkg::*;
#(
    parameter int STEP = STEP_CYCLES
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    input  wire logic        stop_request_i,
    input  wire logic        stop_permit_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic             reset_n_o,
    output logic             stop_entered_o
);
    import wdg_pkg::*;

    logic [31:0] addr_q;
    logic        wr_q;
    logic        rd_q;
    logic [6:0]  count_q;
    logic        act_q;
    logic [4:0]  opt_q;
    logic        stop_q;
    logic        rst_pend_q;
    logic [3:0]  pulse_q;
    logic [31:0] rdata_q;
    logic        hw_opt;
    logic        ext_opt;
    logic        active;
    logic        count_wr;
    logic [6:0]  wr_count;

    wdg_tick_if tick_if ();

    wdg_divider #(
        .STEP (STEP)
    ) divider_u (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_if (tick_if)
    );

    // Map register byte to physical counter, count bits reversed
    function automatic logic [6:0] reg_to_count(input logic [7:0] v);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 0; i < 6; i++)
            c[i] = v[7 - i]; // RL15
        c[6] = v[GUARD_POS];
        return c;
    endfunction : reg_to_count

    function automatic logic [7:0] count_to_reg(input logic [6:0] c, input logic a);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 6; i++)
            v[7 - i] = c[i]; // RL15
        v[GUARD_POS] = c[6];
        v[ACT_POS]   = a;
        return v;
    endfunction : count_to_reg

    // Option bits: 0 hardware activation, 1 external stop control
    assign hw_opt   = opt_q[0];
    assign ext_opt  = opt_q[1];
    assign active   = act_q | hw_opt; // RL1
    assign count_wr = wr_q && (addr_q == COUNT_REG_OFFSET);
    assign wr_count = reg_to_count(hwdata_i[7:0]);

    // Divider control: restart on count write, freeze in stop
    assign tick_if.restart = count_wr; // RL18
    assign tick_if.run     = !stop_q; // RL17

    // Address phase capture
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            addr_q <= 32'h0000_0000;
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
        end
        else if (hready_i)
        begin
            addr_q <= haddr_i;
            wr_q   <= hsel_i && htrans_i[1] && hwrite_i && (hsize_i == HSIZE_WORD);
            rd_q   <= hsel_i && htrans_i[1] && !hwrite_i && (hsize_i == HSIZE_WORD);
        end
        else
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end
    end

    // Option register, loaded by software as strap settings
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            opt_q <= OPTION_RESET_VALUE;
        else if (wr_q && addr_q == OPTION_REG_OFFSET)
            opt_q <= hwdata_i[4:0];
    end

    // Activation bit: set once, only reset clears it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            act_q <= 1'b0; // RL2
        else if (count_wr && hwdata_i[ACT_POS])
            act_q <= 1'b1; // RL2
    end

    // Downcounter: write reload wins over decrement
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count_q <= reg_to_count(COUNT_RESET_VALUE); // RL16
        else if (count_wr)
            count_q <= wr_count; // RL18
        else if (tick_if.tick)
            count_q <= count_q - 7'h01; // RL3 RL4 RL8
    end

    // Reset request: guard at zero or guard written zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rst_pend_q <= 1'b0;
        else if (count_wr && !hwdata_i[GUARD_POS] && (active || hwdata_i[ACT_POS]))
            rst_pend_q <= 1'b1; // RL10
        else if (active && !count_q[6])
            rst_pend_q <= 1'b1; // RL5
        else
            rst_pend_q <= 1'b0;
    end

    // Reset pulse low for a fixed number of cycles
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pulse_q   <= 4'h0;
            reset_n_o <= 1'b1;
        end
        else if (pulse_q != 4'h0)
        begin
            pulse_q   <= pulse_q - 4'h1;
            reset_n_o <= (pulse_q == 4'h1);
        end
        else if (rst_pend_q)
        begin
            pulse_q   <= 4'(RESET_PULSE_CYCLES); // RL5
            reset_n_o <= 1'b0;
        end
    end

    // Stop handling: freeze when inactive, or with external control and pin high
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            stop_q <= 1'b0;
        else if (stop_request_i)
            stop_q <= !active || (ext_opt && stop_permit_i); // RL17
        else if (!stop_request_i)
            stop_q <= 1'b0;
    end
    assign stop_entered_o = stop_q;

    // Read data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_q <= 32'h0000_0000;
        else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
        begin
            if (haddr_i == COUNT_REG_OFFSET)
                rdata_q <= {24'h000000, count_to_reg(count_q, active)};
            else if (haddr_i == OPTION_REG_OFFSET)
                rdata_q <= {27'h0, opt_q};
            else if (haddr_i == STATUS_REG_OFFSET)
                rdata_q <= {29'h0, stop_q, !reset_n_o, active};
            else
                rdata_q <= 32'h0000_0000;
        end
    end
    assign hrdata_o    = rdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // Guard bit at zero while active brings reset within two cycles
    guard_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (active && !count_q[6] && pulse_q == 4'h0 && reset_n_o) |-> ##[1:2] !reset_n_o)
        else $error("guard zero did not reset"); // RL5
    // Activation never drops once set
    act_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
        act_q |=> act_q)
        else $error("activation bit cleared"); // RL2
    // Hardware option reads activation high
    hw_active_a: assert property (@(posedge clk_i) disable iff (rst_i)
        hw_opt |-> active)
        else $error("hardware option not active"); // RL1
    // Decrement by exactly one on a tick
    step_dec_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick_if.tick && !count_wr) |=> count_q == $past(count_q) - 7'h01)
        else $error("counter step wrong"); // RL3
    // Count unchanged without tick or write
    hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!tick_if.tick && !count_wr) |=> $stable(count_q))
        else $error("counter moved without tick"); // RL4
    // Write loads counter
    write_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        count_wr |=> count_q == $past(wr_count))
        else $error("write not loaded"); // RL18
    // Guard cleared by write while active resets
    soft_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (count_wr && active && !hwdata_i[GUARD_POS] && pulse_q == 4'h0) |=> ##1 !reset_n_o)
        else $error("software reset missing"); // RL10
    // Stop frozen only with external control and pin high while active
    stop_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (stop_request_i && active && !(ext_opt && stop_permit_i)) |=> !stop_q)
        else $error("stop entered illegally"); // RL17
    // Pulse low lasts the fixed length
    pulse_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(reset_n_o) |-> !reset_n_o [*5])
        else $error("reset pulse too short"); // RL5
endmodule : wdg_top
`default_nettype wire

// ==== rtl/wdg_pkg.sv ====
// Package with watchdog constants and register offsets
package wdg_pkg;
    localparam logic [31:0] COUNT_REG_OFFSET  = 32'h0000_0000;
    localparam logic [31:0] OPTION_REG_OFFSET = 32'h0000_0004;
    localparam logic [31:0] STATUS_REG_OFFSET = 32'h0000_0008;
    localparam logic [7:0]  COUNT_RESET_VALUE = 8'hFE;
    localparam int          GUARD_POS         = 1;
    localparam int          ACT_POS           = 0;
    localparam int          STEP_CYCLES       = 3072;
    localparam int          CLK_PERIOD_NS     = 100;
    localparam int          RESET_PULSE_NS    = 500;
    localparam int          RESET_PULSE_CYCLES =
        (RESET_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 : (RESET_PULSE_NS / CLK_PERIOD_NS);
    localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
    localparam logic [2:0]  HSIZE_WORD        = 3'h2;
    localparam logic [4:0]  OPTION_RESET_VALUE = 5'h00;
endpackage : wdg_pkg

// ==== rtl/wdg_tick_if.sv ====
// Interface carrying the decrement tick between divider and core
`timescale 1ns/1ps
`default_nettype none
interface wdg_tick_if;
    logic restart;
    logic run;
    logic tick;
    modport divider (input restart, input run, output tick);
    modport core    (output restart, output run, input tick);
endinterface : wdg_tick_if
`default_nettype wire

// ==== rtl/wdg_divider.sv ====
// Divider making one enable pulse per decrement period
`timescale 1ns/1ps
`default_nettype none
module wdg_divider
    import wdg_pkg::*;
#(
    parameter int STEP = STEP_CYCLES
)(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    wdg_tick_if.divider tick_if
);
    localparam int W = $clog2(STEP);
    logic [W-1:0] cnt_q;
    logic         tick_q;

    // Count period, restart on software write, hold while frozen
    always_ff @(posedge clk_i)
    begin
        if (rst_i || tick_if.restart)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (tick_if.run)
        begin
            if (cnt_q == W'(STEP - 1))
            begin
                cnt_q  <= '0;
                tick_q <= 1'b1; // RL3
            end
            else
            begin
                cnt_q  <= cnt_q + W'(1);
                tick_q <= 1'b0;
            end
        end
        else
        begin
            tick_q <= 1'b0;
        end
    end
    assign tick_if.tick = tick_q;
endmodule : wdg_divider
`default_nettype wire

// ==== testbench/wdg_partner.sv ====
// Far-side model: reset line monitor and stop-permit pin
`timescale 1ns/1ps
`default_nettype none
module wdg_partner (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic hold_low_i,
    output logic      stop_permit_o,
    output int        pulses_o,
    output int        width_o
);
    int run_q = 0;
    int pul_q = 0;
    int wid_q = 0;
    // Pin pulled high unless the port line holds it low
    assign stop_permit_o = hold_low_i ? 1'b0 : 1'b1;
    assign pulses_o      = pul_q;
    assign width_o       = wid_q;
    // Count finished reset pulses and measure their length
    always @(posedge clk_i)
    begin
        if (reset_n_i === 1'b0)
            run_q <= run_q + 1;
        else if (run_q != 0)
        begin
            pul_q <= pul_q + 1;
            wid_q <= run_q;
            run_q <= 0;
        end
    end
endmodule : wdg_partner
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import wdg_pkg::*;
    localparam int STP = 8;
    logic        clk_i = 0, rst_i = 1, hsel = 0, hwrite = 0, stop_req = 0, hold_low = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, lfsr = 32'hFA00E51F;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 0;
    logic        hreadyout, hresp, reset_n, stop_ent, permit;
    int          fail_count = 0, total_checks = 0, cyc = 0, pulses, width, k, n, c, exp_p;

    always #50 clk_i = ~clk_i;

    wdg_top #(.STEP(STP)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hreadyout), .stop_request_i(stop_req),
        .stop_permit_i(permit), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
        .hresp_o(hresp), .reset_n_o(reset_n), .stop_entered_o(stop_ent));

    wdg_partner u_partner (.clk_i(clk_i), .reset_n_i(reset_n), .hold_low_i(hold_low),
        .stop_permit_o(permit), .pulses_o(pulses), .width_o(width));

    // Model of the register image: count bits reversed, guard, activation
    function automatic logic [7:0] enc(input int cv, input logic a);
        logic [7:0] r;
        for (int i = 0; i < 6; i++)
            r[7-i] = cv[i];
        r[1] = cv[6];
        r[0] = a;
        return r;
    endfunction : enc

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tk(input int m);
        repeat (m) @(posedge clk_i);
    endtask : tk

    // One AHB-Lite single transfer, read data kept in rd
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= HSIZE_WORD;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic do_reset();
        rst_i <= 1'b1;
        tk(20);
        rst_i <= 1'b0;
        tk(1);
        exp_p = pulses;
    endtask : do_reset

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // Hang guard
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            summarize();
        end
    end

    initial
    begin
        do_reset();
        // Reset values and an unmapped place
        bus(0, COUNT_REG_OFFSET, 0);
        check("count reset", rd, {24'h0, COUNT_RESET_VALUE});
        bus(0, STATUS_REG_OFFSET, 0);
        check("inactive", rd[0], 1'b0);
        bus(1, 32'h0000_0010, 32'hFF);
        bus(0, 32'h0000_0010, 0);
        check("unmapped", rd, 0);
        check("okay response", hresp, 1'b0);
        // Plain timer with random start values
        repeat (4)
        begin
            lfsr = nxt(lfsr);
            c = 64 + int'(lfsr[5:0]);
            n = 1 + int'(lfsr[9:8]);
            bus(1, COUNT_REG_OFFSET, enc(c, 1'b0));
            tk(n * STP + 2);
            bus(0, COUNT_REG_OFFSET, 0);
            check("timer", rd, enc(c - n, 1'b0));
        end
        $display("test timer done");
        // Activation sticks, refresh keeps the device alive
        bus(1, COUNT_REG_OFFSET, enc(127, 1'b1));
        bus(1, COUNT_REG_OFFSET, enc(127, 1'b0));
        bus(0, STATUS_REG_OFFSET, 0);
        check("act sticks", rd[0], 1'b1);
        repeat (6)
        begin
            bus(1, COUNT_REG_OFFSET, enc(65, 1'b1));
            tk(10);
        end
        check("refresh", pulses, exp_p);
        // Timeout after k+1 periods
        k = int'(lfsr[11:10]);
        bus(1, COUNT_REG_OFFSET, enc(64 + k, 1'b1));
        tk((k + 1) * STP - 4);
        check("early reset", reset_n, 1'b1);
        n = 0;
        while (reset_n !== 1'b0 && n < 12)
        begin
            @(posedge clk_i);
            n++;
        end
        check("timeout reset", reset_n, 1'b0);
        tk(7);
        check("pulse width", width, RESET_PULSE_CYCLES);
        check("pulse count", pulses, exp_p + 1);
        $display("test timeout done");
        // Guard written low while active
        do_reset();
        bus(1, COUNT_REG_OFFSET, enc(127, 1'b1));
        bus(0, COUNT_REG_OFFSET, 0);
        check("act test", rd[0], 1'b1);
        bus(1, COUNT_REG_OFFSET, enc(63, 1'b1));
        tk(10);
        check("soft reset", pulses, exp_p + 1);
        // Hardware activation option
        do_reset();
        bus(1, OPTION_REG_OFFSET, 1);
        bus(1, COUNT_REG_OFFSET, enc(127, 1'b0));
        bus(0, COUNT_REG_OFFSET, 0);
        check("hw forced", rd[0], 1'b1);
        stop_req <= 1'b1;
        tk(3);
        check("stop as wait no ext", stop_ent, 1'b0);
        stop_req <= 1'b0;
        $display("test software reset and option done");
        // Stop while inactive, then with external control
        do_reset();
        stop_req <= 1'b1;
        tk(3);
        check("stop inactive", stop_ent, 1'b1);
        stop_req <= 1'b0;
        tk(2);
        bus(1, OPTION_REG_OFFSET, 3);
        bus(1, COUNT_REG_OFFSET, enc(127, 1'b1));
        stop_req <= 1'b1;
        tk(3);
        check("stop entered", stop_ent, 1'b1);
        tk(3 * STP);
        bus(0, COUNT_REG_OFFSET, 0);
        check("frozen", rd, enc(127, 1'b1));
        hold_low <= 1'b1;
        tk(3);
        check("stop as wait", stop_ent, 1'b0);
        stop_req <= 1'b0;
        hold_low <= 1'b0;
        $display("test stop done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
